// >>> hw/rtcisu_pkg.sv
// constants, types and helpers for the rtc interrupt, status and update block
// assumes a 25 MHz system clock and a 32.768 kHz time base pin
package rtcisu_pkg;
    localparam int TB_HZ = 32768;
    localparam int UIP_LEAD_US = 244;
    localparam int UPD_US = 1984;
    // least times, rounded up to whole time base ticks
    localparam int UIP_LEAD_TICKS = (UIP_LEAD_US * TB_HZ + 999999) / 1000000;
    localparam int UPD_TICKS = (UPD_US * TB_HZ + 999999) / 1000000;
    localparam logic [14:0] DIV_WRAP = 15'h7FFF;
    localparam logic [14:0] DIV_HALF = 15'h4000;
    localparam logic [14:0] UIP_AT = 15'(TB_HZ - UIP_LEAD_TICKS);
    localparam logic [6:0] UPD_LAST = 7'(UPD_TICKS - 1);
    // index map
    localparam logic [6:0] IDX_SEC = 7'h00;
    localparam logic [6:0] IDX_ASEC = 7'h01;
    localparam logic [6:0] IDX_MIN = 7'h02;
    localparam logic [6:0] IDX_AMIN = 7'h03;
    localparam logic [6:0] IDX_HR = 7'h04;
    localparam logic [6:0] IDX_AHR = 7'h05;
    localparam logic [6:0] IDX_DOW = 7'h06;
    localparam logic [6:0] IDX_DATE = 7'h07;
    localparam logic [6:0] IDX_MON = 7'h08;
    localparam logic [6:0] IDX_YEAR = 7'h09;
    localparam logic [6:0] IDX_CTRL_A = 7'h0A;
    localparam logic [6:0] IDX_CTRL_B = 7'h0B;
    localparam logic [6:0] IDX_FLAGS = 7'h0C;
    localparam logic [6:0] IDX_VALID = 7'h0D;
    localparam logic [6:0] IDX_RAM = 7'h0E;
    localparam logic [6:0] IDX_XRAM = 7'h40;
    // control register b and a fields, then other constants
    localparam int B_H24 = 1;
    localparam int B_BIN = 2;
    localparam int B_UIE = 4;
    localparam int B_AIE = 5;
    localparam int B_PIE = 6;
    localparam int B_SET = 7;
    localparam int A_DIVRST = 6;
    localparam logic [1:0] DV_FIXED = 2'h2;
    localparam logic [7:0] LOCKOUT_DATA = 8'hFF;
    localparam logic [1:0] DONT_CARE = 2'h3;
    localparam logic [3:0] RATE_SHORT = 4'h3;
    localparam logic [3:0] RATE_ALIAS = 4'h7;

    typedef struct packed {
        logic sel;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } rtcisu_io_req_s;

    typedef struct packed {
        logic [1:0] ps_sy;
        logic [1:0] br_sy;
        logic [1:0] tb_sy;
        logic tb_last;
        logic [14:0] div;
        logic [6:0] upd_cnt;
        logic in_upd;
        logic update_pending_bit;
        logic [3:0] rate;
        logic div_rst;
        logic [7:0] ctrl_b;
        logic uf;
        logic af;
        logic pf;
        logic ram_valid_bit;
        logic [6:0] index;
        logic [7:0] rdata;
        logic [9:0][7:0] tm;
        logic [49:0][7:0] ram;
        logic [127:0][7:0] xram;
    } rtcisu_state_s;

    function automatic logic [7:0] bcd2bin(input logic [7:0] v);
        // widen before the product so the tens digit is not cut to 4 bits
        bcd2bin = {4'h0, v[7:4]} * 8'hA + {4'h0, v[3:0]};
    endfunction

    function automatic logic [7:0] bin2bcd(input logic [7:0] v);
        logic [7:0] t;
        t = v / 8'hA;
        bin2bcd = {t[3:0], 4'(v - 8'(t * 8'hA))};
    endfunction
endpackage

// >>> hw/rtcisu_incr.sv
// one time or calendar counter step in binary or bcd
// assumes lo and hi are binary and the value is in range
`timescale 1ns/10ps
module rtcisu_incr (
    input wire logic [7:0] val,
    input wire logic bin,
    input wire logic [7:0] lo,
    input wire logic [7:0] hi,
    output logic [7:0] next,
    output logic wrap
);
    logic [7:0] b;
    logic [7:0] nb;

    always_comb begin
        b = bin ? val : rtcisu_pkg::bcd2bin(val);
        wrap = b >= hi;
        nb = wrap ? lo : 8'(b + 8'h1);
        next = bin ? nb : rtcisu_pkg::bin2bcd(nb);
    end
endmodule

// >>> hw/rtcisu_tap.sv
// periodic tap select on the time base divider
// assumes cur and nxt are the divider before and after a tick
`timescale 1ns/10ps
module rtcisu_tap (
    input wire logic [14:0] cur,
    input wire logic [14:0] nxt,
    input wire logic [3:0] rate,
    output logic tick
);
    logic [3:0] r;

    always_comb begin
        // rates 1 and 2 repeat the 3.9 ms and 7.8 ms taps
        r = (rate < rtcisu_pkg::RATE_SHORT && rate != 4'h0)
            ? 4'(rate + rtcisu_pkg::RATE_ALIAS) : rate;
        tick = 1'b0;
        if (r != 4'h0) begin
            // falling edge of bit r-2 gives a period of 2^(r-1) ticks
            tick = cur[r - 4'h2] && !nxt[r - 4'h2];
        end
    end
endmodule

// >>> hw/rtcisu_top.sv
// rtc flags, valid status, standby ram banks and the once a second update
// assumes the index/data port pair is decoded outside; all pins are async
//
// Operation
// - update end sets update_done_flag
// - flags clear on flags read or bus reset
// - alarm match sets alarm_match_flag
// - periodic tap edge sets flag regardless enable
// - request flag is or of enabled flags
// - irq pin active while request flag set
// - flags bits 0-3 read zero, unwritable
// - status bits 0-6 read zero, unwritable
// - valid bit zero while power sense low
// - valid bit set only by status read
// - 128 extra bytes, two banks at 64-127
// - increments follow binary or bcd format
// - 12 hour pm bit, 24 hour 0-23
// - one update per second when running, not set
// - overflow ripples seconds through year
// - alarm bytes c0-ff match anything
// - time bytes read ff during update, writes still land
// - update pending bit leads update by 244us
// - set mode aborts and blocks updates
// - first update half second after divider release
// - periodic rates 500 ms to 122.070 us
// - enabling a set flag asserts irq at once
// - irq pin open drain, low or released
`timescale 1ns/10ps
module rtcisu_top (
    input wire logic sys_clk,
    input wire logic rst,
    input wire rtcisu_pkg::rtcisu_io_req_s io_req,
    output logic [7:0] io_rdata,
    input wire logic bus_reset_pin,
    input wire logic power_sense_in,
    input wire logic timebase_in,
    input wire logic extra_ram_bank_select,
    input wire logic clock_irq_n_in,
    output logic clock_irq_n_out,
    output logic clock_irq_n_oe
);
    rtcisu_pkg::rtcisu_state_s s_reg;
    rtcisu_pkg::rtcisu_state_s s_next;

    logic tb_tick;
    logic br;
    logic ps;
    logic running;
    logic [14:0] div_nxt;
    logic per_tick;
    logic upd_done;
    logic alarm_hit;
    logic request_pending_flag;
    logic rd_flags;
    logic rd_valid;
    logic wr_data;
    logic h24;
    logic bin;
    logic pm;
    logic day_carry;
    logic [7:0] hr_val;
    logic [7:0] hr_new;
    logic [7:0] dim;
    logic [7:0] mon_b;
    logic [7:0] yr_b;
    logic [6:0][7:0] inc_val;
    logic [6:0][7:0] inc_lo;
    logic [6:0][7:0] inc_hi;
    logic [6:0][7:0] inc_nxt;
    logic [6:0] inc_wrap;
    logic [7:0] rd_mux;

    // counters: 0 sec, 1 min, 2 hour, 3 dow, 4 date, 5 month, 6 year
    genvar gi;
    generate
        for (gi = 0; gi < 7; gi++) begin : g_inc
            rtcisu_incr u_inc (
                .val(inc_val[gi]),
                .bin(bin),
                .lo(inc_lo[gi]),
                .hi(inc_hi[gi]),
                .next(inc_nxt[gi]),
                .wrap(inc_wrap[gi])
            );
        end
    endgenerate

    rtcisu_tap u_tap (
        .cur(s_reg.div),
        .nxt(div_nxt),
        .rate(s_reg.rate),
        .tick(per_tick)
    );

    always_comb begin
        tb_tick = s_reg.tb_sy[1] && !s_reg.tb_last;
        br = s_reg.br_sy[1];
        ps = s_reg.ps_sy[1];
        h24 = s_reg.ctrl_b[rtcisu_pkg::B_H24];
        bin = s_reg.ctrl_b[rtcisu_pkg::B_BIN];
        running = !s_reg.div_rst && !s_reg.ctrl_b[rtcisu_pkg::B_SET];
        div_nxt = s_reg.div;
        if (s_reg.div_rst) begin
            div_nxt = rtcisu_pkg::DIV_HALF;
        end else if (tb_tick) begin
            div_nxt = 15'(s_reg.div + 15'h1);
        end
        upd_done = tb_tick && s_reg.in_upd
            && s_reg.upd_cnt == rtcisu_pkg::UPD_LAST;
        rd_flags = io_req.rd && io_req.sel
            && s_reg.index == rtcisu_pkg::IDX_FLAGS;
        rd_valid = io_req.rd && io_req.sel
            && s_reg.index == rtcisu_pkg::IDX_VALID;
        wr_data = io_req.wr && io_req.sel;
        request_pending_flag =
            (s_reg.pf && s_reg.ctrl_b[rtcisu_pkg::B_PIE])
            || (s_reg.af && s_reg.ctrl_b[rtcisu_pkg::B_AIE])
            || (s_reg.uf && s_reg.ctrl_b[rtcisu_pkg::B_UIE]);
    end

    // calendar step, all counters fed from the current time bytes
    always_comb begin
        hr_val = h24 ? s_reg.tm[rtcisu_pkg::IDX_HR]
            : {1'b0, s_reg.tm[rtcisu_pkg::IDX_HR][6:0]};
        pm = s_reg.tm[rtcisu_pkg::IDX_HR][7];
        mon_b = bin ? s_reg.tm[rtcisu_pkg::IDX_MON]
            : rtcisu_pkg::bcd2bin(s_reg.tm[rtcisu_pkg::IDX_MON]);
        yr_b = bin ? s_reg.tm[rtcisu_pkg::IDX_YEAR]
            : rtcisu_pkg::bcd2bin(s_reg.tm[rtcisu_pkg::IDX_YEAR]);
        unique case (mon_b)
            8'h02: dim = (yr_b[1:0] == 2'h0) ? 8'h1D : 8'h1C;
            8'h04, 8'h06, 8'h09, 8'h0B: dim = 8'h1E;
            default: dim = 8'h1F;
        endcase
        inc_val[0] = s_reg.tm[rtcisu_pkg::IDX_SEC];
        inc_val[1] = s_reg.tm[rtcisu_pkg::IDX_MIN];
        inc_val[2] = hr_val;
        inc_val[3] = s_reg.tm[rtcisu_pkg::IDX_DOW];
        inc_val[4] = s_reg.tm[rtcisu_pkg::IDX_DATE];
        inc_val[5] = s_reg.tm[rtcisu_pkg::IDX_MON];
        inc_val[6] = s_reg.tm[rtcisu_pkg::IDX_YEAR];
        inc_lo = {8'h00, 8'h01, 8'h01, 8'h01,
            h24 ? 8'h00 : 8'h01, 8'h00, 8'h00};
        inc_hi = {8'h63, 8'h0C, dim, 8'h07,
            h24 ? 8'h17 : 8'h0C, 8'h3B, 8'h3B};
        // 12 hour: 11 -> 12 flips pm; pm 11 -> am 12 ends the day
        if (h24) begin
            day_carry = inc_wrap[2];
            hr_new = inc_nxt[2];
        end else begin
            day_carry = pm && inc_nxt[2] == (bin ? 8'h0C : 8'h12);
            hr_new = {pm ^ (inc_nxt[2] == (bin ? 8'h0C : 8'h12)),
                inc_nxt[2][6:0]};
        end
    end

    always_comb begin
        rd_mux = 8'h00;
        if (s_reg.index < rtcisu_pkg::IDX_CTRL_A) begin
            // bus sees no time bytes while the update owns them
            rd_mux = s_reg.in_upd ? rtcisu_pkg::LOCKOUT_DATA
                : s_reg.tm[s_reg.index[3:0]];
        end else if (s_reg.index == rtcisu_pkg::IDX_CTRL_A) begin
            rd_mux = {s_reg.update_pending_bit, s_reg.div_rst, rtcisu_pkg::DV_FIXED,
                s_reg.rate};
        end else if (s_reg.index == rtcisu_pkg::IDX_CTRL_B) begin
            rd_mux = s_reg.ctrl_b;
        end else if (s_reg.index == rtcisu_pkg::IDX_FLAGS) begin
            rd_mux = {request_pending_flag, s_reg.pf, s_reg.af,
                s_reg.uf, 4'h0};
        end else if (s_reg.index == rtcisu_pkg::IDX_VALID) begin
            rd_mux = {s_reg.ram_valid_bit, 7'h00};
        end else if (s_reg.index < rtcisu_pkg::IDX_XRAM) begin
            rd_mux = s_reg.ram[6'(s_reg.index - rtcisu_pkg::IDX_RAM)];
        end else begin
            rd_mux = s_reg.xram[{extra_ram_bank_select,
                s_reg.index[5:0]}];
        end
    end

    always_comb begin
        s_next = s_reg;
        s_next.ps_sy = {s_reg.ps_sy[0], power_sense_in};
        s_next.br_sy = {s_reg.br_sy[0], bus_reset_pin};
        s_next.tb_sy = {s_reg.tb_sy[0], timebase_in};
        s_next.tb_last = s_reg.tb_sy[1];
        s_next.div = div_nxt;
        alarm_hit = 1'b0;
        if (io_req.rd && io_req.sel) begin
            s_next.rdata = rd_mux;
        end
        if (io_req.wr && !io_req.sel) begin
            s_next.index = io_req.wdata[6:0];
        end
        if (running && tb_tick) begin
            if (div_nxt == rtcisu_pkg::UIP_AT) begin
                s_next.update_pending_bit = 1'b1;
            end
            if (div_nxt == 15'h0) begin
                s_next.in_upd = 1'b1;
                s_next.upd_cnt = 7'h0;
            end else if (s_reg.in_upd) begin
                s_next.upd_cnt = 7'(s_reg.upd_cnt + 7'h1);
            end
        end
        if (running && upd_done) begin
            s_next.in_upd = 1'b0;
            s_next.update_pending_bit = 1'b0;
            s_next.tm[rtcisu_pkg::IDX_SEC] = inc_nxt[0];
            if (inc_wrap[0]) begin
                s_next.tm[rtcisu_pkg::IDX_MIN] = inc_nxt[1];
                if (inc_wrap[1]) begin
                    s_next.tm[rtcisu_pkg::IDX_HR] = hr_new;
                    if (day_carry) begin
                        s_next.tm[rtcisu_pkg::IDX_DOW] = inc_nxt[3];
                        s_next.tm[rtcisu_pkg::IDX_DATE] = inc_nxt[4];
                        if (inc_wrap[4]) begin
                            s_next.tm[rtcisu_pkg::IDX_MON] = inc_nxt[5];
                            if (inc_wrap[5]) begin
                                s_next.tm[rtcisu_pkg::IDX_YEAR] = inc_nxt[6];
                            end
                        end
                    end
                end
            end
            alarm_hit =
                (s_reg.tm[rtcisu_pkg::IDX_ASEC][7:6] == rtcisu_pkg::DONT_CARE
                || s_reg.tm[rtcisu_pkg::IDX_ASEC]
                == s_next.tm[rtcisu_pkg::IDX_SEC])
                && (s_reg.tm[rtcisu_pkg::IDX_AMIN][7:6]
                == rtcisu_pkg::DONT_CARE
                || s_reg.tm[rtcisu_pkg::IDX_AMIN]
                == s_next.tm[rtcisu_pkg::IDX_MIN])
                && (s_reg.tm[rtcisu_pkg::IDX_AHR][7:6] == rtcisu_pkg::DONT_CARE
                || s_reg.tm[rtcisu_pkg::IDX_AHR]
                == s_next.tm[rtcisu_pkg::IDX_HR]);
        end
        if (wr_data) begin
            if (s_reg.index < rtcisu_pkg::IDX_CTRL_A) begin
                s_next.tm[s_reg.index[3:0]] = io_req.wdata;
            end else if (s_reg.index == rtcisu_pkg::IDX_CTRL_A) begin
                s_next.rate = io_req.wdata[3:0];
                s_next.div_rst = io_req.wdata[rtcisu_pkg::A_DIVRST];
            end else if (s_reg.index == rtcisu_pkg::IDX_CTRL_B) begin
                s_next.ctrl_b = io_req.wdata;
                if (io_req.wdata[rtcisu_pkg::B_SET]
                    && !s_reg.ctrl_b[rtcisu_pkg::B_SET]) begin
                    s_next.ctrl_b[rtcisu_pkg::B_UIE] = 1'b0;
                end
            end else if (s_reg.index >= rtcisu_pkg::IDX_XRAM) begin
                s_next.xram[{extra_ram_bank_select,
                    s_reg.index[5:0]}] = io_req.wdata;
            end else if (s_reg.index >= rtcisu_pkg::IDX_RAM) begin
                s_next.ram[6'(s_reg.index - rtcisu_pkg::IDX_RAM)] =
                    io_req.wdata;
            end
        end
        // set mode drops a running update; the bytes stay as they were
        if (s_next.ctrl_b[rtcisu_pkg::B_SET]) begin
            s_next.in_upd = 1'b0;
            s_next.update_pending_bit = 1'b0;
        end
        if (br) begin
            s_next.ctrl_b[rtcisu_pkg::B_UIE] = 1'b0;
            s_next.ctrl_b[rtcisu_pkg::B_AIE] = 1'b0;
            s_next.ctrl_b[rtcisu_pkg::B_PIE] = 1'b0;
        end
        // clear first, then sets, so an event in the clearing cycle stays
        if (rd_flags || br) begin
            s_next.uf = 1'b0;
            s_next.af = 1'b0;
            s_next.pf = 1'b0;
        end
        if (running && upd_done) begin
            s_next.uf = 1'b1;
        end
        if (alarm_hit) begin
            s_next.af = 1'b1;
        end
        // a divider forced to its half count makes no tap edges
        if (per_tick && tb_tick && !s_reg.div_rst) begin
            s_next.pf = 1'b1;
        end
        // bus reset leaves the valid bit alone
        s_next.ram_valid_bit = ps && (s_reg.ram_valid_bit || rd_valid);
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign io_rdata = s_reg.rdata;
    // open drain: only ever pulls low, the wire-or is outside
    assign clock_irq_n_out = 1'b0;
    assign clock_irq_n_oe = request_pending_flag;

    property p_irq_follows;
        @(posedge sys_clk) disable iff (rst)
        (s_reg.uf && s_reg.ctrl_b[rtcisu_pkg::B_UIE]) |-> clock_irq_n_oe;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("irq not driven with enabled update flag");

    property p_no_irq;
        @(posedge sys_clk) disable iff (rst)
        !s_reg.uf && !s_reg.af && !s_reg.pf |-> !clock_irq_n_oe;
    endproperty
    a_no_irq: assert property (p_no_irq)
        else $error("irq driven with no flag set");

    property p_clear_read;
        @(posedge sys_clk) disable iff (rst)
        rd_flags && !tb_tick |=> !s_reg.uf && !s_reg.af && !s_reg.pf;
    endproperty
    a_clear_read: assert property (p_clear_read)
        else $error("flags survive a flags read");

    property p_old_flags;
        @(posedge sys_clk) disable iff (rst)
        rd_flags |=> io_rdata[6:4] == {$past(s_reg.pf), $past(s_reg.af),
            $past(s_reg.uf)} && io_rdata[3:0] == 4'h0;
    endproperty
    a_old_flags: assert property (p_old_flags)
        else $error("flags read data wrong");

    property p_valid_low;
        @(posedge sys_clk) disable iff (rst)
        rd_valid |=> io_rdata[6:0] == 7'h00;
    endproperty
    a_valid_low: assert property (p_valid_low)
        else $error("status low bits not zero");

    property p_vrt_ps;
        @(posedge sys_clk) disable iff (rst)
        !s_reg.ps_sy[1] |=> !s_reg.ram_valid_bit;
    endproperty
    a_vrt_ps: assert property (p_vrt_ps)
        else $error("valid bit set without power sense");

    property p_vrt_set;
        @(posedge sys_clk) disable iff (rst)
        !s_reg.ram_valid_bit && !rd_valid |=> !s_reg.ram_valid_bit;
    endproperty
    a_vrt_set: assert property (p_vrt_set)
        else $error("valid bit set without a status read");

    property p_set_blocks;
        @(posedge sys_clk) disable iff (rst)
        s_reg.ctrl_b[rtcisu_pkg::B_SET] |-> !s_reg.in_upd && !s_reg.update_pending_bit;
    endproperty
    a_set_blocks: assert property (p_set_blocks)
        else $error("update runs in set mode");

    property p_uf_set;
        @(posedge sys_clk) disable iff (rst)
        running && upd_done |=> s_reg.uf && !s_reg.in_upd;
    endproperty
    a_uf_set: assert property (p_uf_set)
        else $error("update end did not set flag");
endmodule

// >>> tb/rtcisu_host.sv
// host model: master of the index/data port pair and the pulled-up irq line
// assumes the bench calls its tasks from one process only
`timescale 1ns/10ps
module rtcisu_host (
    input wire logic sys_clk,
    output rtcisu_pkg::rtcisu_io_req_s io_req,
    input wire logic [7:0] io_rdata,
    input wire logic irq_oe,
    input wire logic irq_out,
    output logic irq_pin
);
    // pull-up wins whenever the device lets go
    assign irq_pin = irq_oe ? irq_out : 1'b1;
    initial io_req = '0;
    // released data lines show the inverse, not a stale copy
    task automatic idle();
        @(negedge sys_clk);
        io_req.wr = 1'b0;
        io_req.rd = 1'b0;
        io_req.wdata = ~io_req.wdata;
    endtask
    task automatic reg_wr(input logic [6:0] idx, input logic [7:0] v);
        @(negedge sys_clk);
        io_req = '{1'b0, 1'b1, 1'b0, {1'b0, idx}};
        @(negedge sys_clk);
        io_req = '{1'b1, 1'b1, 1'b0, v};
        idle();
    endtask
    task automatic reg_rd(input logic [6:0] idx, output logic [7:0] v);
        @(negedge sys_clk);
        io_req = '{1'b0, 1'b1, 1'b0, {1'b0, idx}};
        @(negedge sys_clk);
        io_req = '{1'b1, 1'b0, 1'b1, ~io_req.wdata};
        idle();
        @(negedge sys_clk);
        v = io_rdata;
    endtask
endmodule

// >>> tb/rtc_interrupt_status_update_bench.sv
// bench: register port sequences against the flag, status and update logic
// assumes the host model above and a sped-up time base
`timescale 1ns/10ps
module rtc_interrupt_status_update_bench;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic bus_reset_pin = 1'b0;
    logic power_sense_in = 1'b0;
    logic timebase_in = 1'b0;
    logic extra_ram_bank_select = 1'b0;
    rtcisu_pkg::rtcisu_io_req_s io_req;
    logic [7:0] io_rdata;
    logic irq_pin;
    logic irq_out;
    logic irq_oe;
    logic [7:0] d;
    int n_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    int t0, t1, t2;
    logic [6:0] ti [0:6] = '{7'h00, 7'h02, 7'h04, 7'h06, 7'h07, 7'h08, 7'h09};
    // bcd 24 hour new year, then binary 12 hour 11 pm on a common feb 28
    logic [7:0] ld [0:1][0:6] = '{
        '{8'h59, 8'h59, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99},
        '{8'h3B, 8'h3B, 8'h8B, 8'h07, 8'h1C, 8'h02, 8'h01}};
    logic [7:0] nx [0:1][0:6] = '{
        '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00},
        '{8'h00, 8'h00, 8'h0C, 8'h01, 8'h01, 8'h03, 8'h01}};
    // don't care alarms first, then an exact 12 am match
    logic [7:0] al [0:1][0:2] = '{
        '{8'hC0, 8'hC0, 8'hC0},
        '{8'h00, 8'h00, 8'h0C}};
    // second set write also asks for uie, which the set rise drops
    logic [7:0] sb [0:1] = '{8'h82, 8'h94};
    logic [7:0] cb [0:1] = '{8'h82, 8'h84};
    logic [7:0] rb [0:1] = '{8'h12, 8'h24};
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    // one tick per two clocks, the fastest the pin synchroniser follows,
    // so two half second waits fit the cycle budget
    always begin
        @(negedge sys_clk);
        timebase_in = ~timebase_in;
    end
    rtcisu_top u_rtcisu_top (
        .sys_clk(sys_clk), .rst(rst), .io_req(io_req), .io_rdata(io_rdata),
        .bus_reset_pin(bus_reset_pin), .power_sense_in(power_sense_in),
        .timebase_in(timebase_in),
        .extra_ram_bank_select(extra_ram_bank_select),
        .clock_irq_n_in(irq_pin), .clock_irq_n_out(irq_out),
        .clock_irq_n_oe(irq_oe)
    );
    rtcisu_host u_rtcisu_host (
        .sys_clk(sys_clk), .io_req(io_req), .io_rdata(io_rdata),
        .irq_oe(irq_oe), .irq_out(irq_out), .irq_pin(irq_pin)
    );
    task automatic results();
        $display("errors %0d compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic bad(input string s);
        n_errors++;
        $display("mismatch t=%0t %s", $time, s);
    endtask
    task automatic chk_byte(input logic [6:0] idx, input logic [7:0] e);
        u_rtcisu_host.reg_rd(idx, d);
        cmp_count++;
        if (d !== e) begin
            bad($sformatf("idx %h got %h exp %h", idx, d, e));
        end
    endtask
    task automatic chk_bit(input logic g, input logic e);
        cmp_count++;
        if (g !== e) begin
            bad($sformatf("pin got %b exp %b", g, e));
        end
    endtask
    // poll skew and tick phase together stay inside 20 clocks
    task automatic chk_span(input int g, input int e);
        cmp_count++;
        if (g < e - 20 || g > e + 20) begin
            bad($sformatf("span got %0d exp %0d", g, e));
        end
    endtask
    task automatic wait_byte(input logic [6:0] idx, input logic [7:0] m,
        input logic [7:0] v, input int lim, output int t);
        int i;
        for (i = 0; i < lim; i++) begin
            u_rtcisu_host.reg_rd(idx, d);
            if ((d & m) === v) break;
        end
        t = cyc;
        if (i == lim) begin
            bad("wait ran out");
            results();
        end
    endtask
    task automatic pause(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic pf_burst();
        u_rtcisu_host.reg_wr(7'h0A, 8'h03);
        pause(40);
        u_rtcisu_host.reg_wr(7'h0A, 8'h40);
    endtask
    initial begin
        pause(4);
        rst = 1'b0;
        chk_byte(7'h0C, 8'h00);
        chk_byte(7'h0A, 8'h20);
        chk_byte(7'h0D, 8'h00);
        chk_byte(7'h0D, 8'h00);
        power_sense_in = 1'b1;
        pause(4);
        u_rtcisu_host.reg_rd(7'h0D, d);
        chk_byte(7'h0D, 8'h80);
        u_rtcisu_host.reg_wr(7'h0D, 8'hFF);
        chk_byte(7'h0D, 8'h80);
        bus_reset_pin = 1'b1;
        pause(4);
        bus_reset_pin = 1'b0;
        pause(4);
        chk_byte(7'h0D, 8'h80);
        power_sense_in = 1'b0;
        pause(4);
        chk_byte(7'h0D, 8'h00);
        u_rtcisu_host.reg_wr(7'h0C, 8'hFF);
        chk_byte(7'h0C, 8'h00);
        for (int b = 0; b < 2; b++) begin
            extra_ram_bank_select = b[0];
            u_rtcisu_host.reg_wr(7'h40, 8'hA0 + 8'(b));
            u_rtcisu_host.reg_wr(7'h7F, 8'h5A ^ 8'(b));
        end
        for (int b = 0; b < 2; b++) begin
            extra_ram_bank_select = b[0];
            chk_byte(7'h40, 8'hA0 + 8'(b));
            chk_byte(7'h7F, 8'h5A ^ 8'(b));
        end
        pf_burst();
        chk_byte(7'h0A, 8'h60);
        chk_bit(irq_oe, 1'b0);
        u_rtcisu_host.reg_wr(7'h0B, 8'h40);
        pause(3);
        chk_bit(irq_oe, 1'b1);
        chk_bit(irq_pin, 1'b0);
        bus_reset_pin = 1'b1;
        pause(4);
        bus_reset_pin = 1'b0;
        pause(4);
        chk_bit(irq_oe, 1'b0);
        chk_byte(7'h0C, 8'h00);
        chk_byte(7'h0B, 8'h00);
        pf_burst();
        u_rtcisu_host.reg_wr(7'h0B, 8'h40);
        chk_byte(7'h0C, 8'hC0);
        pause(3);
        chk_bit(irq_oe, 1'b0);
        chk_bit(irq_pin, 1'b1);
        chk_byte(7'h0C, 8'h00);
        // time is loaded under set mode, before any rollover is due
        for (int k = 0; k < 2; k++) begin
            u_rtcisu_host.reg_wr(7'h0A, 8'h40);
            u_rtcisu_host.reg_wr(7'h0B, sb[k]);
            chk_byte(7'h0B, cb[k]);
            for (int i = 0; i < 7; i++) begin
                u_rtcisu_host.reg_wr(ti[i], ld[k][i]);
            end
            for (int i = 0; i < 3; i++) begin
                u_rtcisu_host.reg_wr(7'(2 * i + 1), al[k][i]);
            end
            u_rtcisu_host.reg_wr(7'h0B, rb[k]);
            u_rtcisu_host.reg_wr(7'h0A, 8'h00);
            t0 = cyc;
            wait_byte(7'h0A, 8'h80, 8'h80, 10000, t1);
            chk_span(t1 - t0, 16376 * 2);
            chk_byte(7'h00, ld[k][0]);
            wait_byte(7'h00, 8'hFF, 8'hFF, 100, t2);
            chk_span(t2 - t1, 8 * 2);
            wait_byte(7'h0A, 8'h80, 8'h00, 200, t1);
            chk_span(t1 - t2, 66 * 2);
            chk_bit(irq_oe, 1'b1);
            chk_byte(7'h0C, 8'hB0);
            for (int i = 0; i < 7; i++) begin
                chk_byte(ti[i], nx[k][i]);
            end
        end
        results();
    end
endmodule
